// *** mies_pkg.sv ***
// package for the instruction execute core: register map, opcodes, carriers
// assumes a 32-bit classic wishbone slave with byte addresses
package mies_pkg;

  // register byte offsets
  localparam logic [7:0] ADR_CMD   = 8'h00;
  localparam logic [7:0] ADR_STAT  = 8'h04;
  localparam logic [7:0] ADR_RDAT  = 8'h08;
  localparam logic [7:0] ADR_CTRL  = 8'h0c;
  localparam logic [7:0] ADR_WDOG  = 8'h10;
  localparam logic [7:0] ADR_STACK = 8'h14;

  // opcodes as written to the command register
  localparam logic [4:0] OP_NOP        = 5'h00;
  localparam logic [4:0] OP_SKIP_SET   = 5'h01;
  localparam logic [4:0] OP_CALL_ACC   = 5'h02;
  localparam logic [4:0] OP_JUMP_ACC   = 5'h03;
  localparam logic [4:0] OP_ZERO_ACC   = 5'h04;
  localparam logic [4:0] OP_ZERO_REG   = 5'h05;
  localparam logic [4:0] OP_KICK_WD    = 5'h06;
  localparam logic [4:0] OP_INVERT     = 5'h07;
  localparam logic [4:0] OP_COMPARE    = 5'h08;
  localparam logic [4:0] OP_MINUS_ONE  = 5'h09;
  localparam logic [4:0] OP_PLUS_ONE   = 5'h0a;
  localparam logic [4:0] OP_DEC_SKZ    = 5'h0b;
  localparam logic [4:0] OP_INC_SKZ    = 5'h0c;
  localparam logic [4:0] OP_BCD_ADJ    = 5'h0d;
  localparam logic [4:0] OP_IRQ_OFF    = 5'h0e;
  localparam logic [4:0] OP_IRQ_ON     = 5'h0f;
  localparam logic [4:0] OP_JUMP_PAGED = 5'h10;
  localparam logic [4:0] OP_OR_REG     = 5'h11;
  localparam logic [4:0] OP_OR_IMM     = 5'h12;
  localparam logic [4:0] OP_WR_FPAGE   = 5'h13;
  localparam logic [4:0] OP_RD_FPAGE   = 5'h14;
  localparam logic [4:0] OP_CALL_LONG  = 5'h15;
  localparam logic [4:0] OP_TRAP       = 5'h16;

  // reset values, vectors and cycle extras
  localparam logic [8:0] PC_RESET    = 9'h000;
  localparam logic [8:0] TRAP_VECTOR = 9'h001;
  localparam logic [1:0] XTRA_BRANCH = 2'h1;
  localparam logic [1:0] XTRA_TRAP   = 2'h2;
  localparam logic       RST_GIE     = 1'b0;
  localparam logic       RST_FLAG_N  = 1'b1;
  localparam logic [3:0] FPAGE_LO    = 4'h6;
  localparam logic [3:0] BCD_MAX     = 4'h9;
  localparam logic [7:0] BCD_LO_FIX  = 8'h06;
  localparam logic [7:0] BCD_HI_FIX  = 8'h60;

  typedef struct packed {
    logic [4:0] op;
    logic       toReg;
    logic [2:0] bitSel;
    logic [8:0] arg;
  } mies_cmd_t;

  typedef struct packed {
    logic       busy;
    logic       skip;
    logic       global_irq_enable;
    logic       toN;
    logic       pdN;
    logic       c;
    logic       z;
    logic [8:0] pc;
    logic [7:0] acc;
  } mies_stat_t;

endpackage

// *** mies_core.sv ***
// instruction execute core for a subset of an 8-bit risc instruction set
// assumes a classic wishbone master; commands arrive one per bus write
// Notes on behaviour
// - bit-test skip: set bit discards next instruction, runs a nop instead
// - call via acc pushes pc+1, jumps to {table high bit0, acc}, two cycles
// - jump via acc targets {table high bit0, acc}, no push, two cycles
// - zero accumulator clears acc and sets zero flag in one cycle
// - zero register clears addressed register 0..63 and sets zero flag
// - watchdog kick clears counter, prescaler if assigned, sets pdN always, and toN unless a timeout falls in the same cycle
// - destination bit 0 writes accumulator, 1 writes source register back
// - invert writes complement to destination, only zero flag changes
// - compare does register minus acc, touches zero and carry only
// - register minus/plus one write destination, update zero, one cycle
// - inc/dec skip store result, no flags, zero result skips next
// - bcd adjust converts acc to packed decimal, only carry changes
// - irq on sets global enable, irq off clears it, one cycle
// - paged jump loads imm into pc low, pc bit8 from high buffer
// - software trap pushes pc+1, jumps to 0x001, three cycles
// - fpage write/read copy acc to/from sfr 6..15, one cycle
// - long call pushes pc+1 and loads full 9-bit address, two cycles
// - carry is 1 when add carries or subtract does not borrow
// - timeout flag low after watchdog timeout, high after kick unless a timeout falls in the same cycle
`timescale 1ns/1ps
module mies_core #(
  parameter int STACK_DEPTH = 4,
  parameter int WDT_W       = 8,
  parameter int PSC_W       = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             globalIrqEnable,
  output logic             timeoutFlagN
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  logic [7:0]        rf [64];
  logic [7:0]        fpage [16];
  logic [8:0]        stk [STACK_DEPTH];
  logic [SP_W-1:0]   sp_ff;
  logic [7:0]        acc_ff;
  logic [8:0]        pc_ff;
  logic              z_ff, c_ff, gie_ff, toN_ff, pdN_ff, skip_ff;
  logic [1:0]        busy_ff;
  logic              table_high_pointer_ff, pc_high_buffer_ff, pscToWdt_ff;
  logic [5:0]        rdSel_ff;
  logic [WDT_W-1:0]  wdt_ff;
  logic [PSC_W-1:0]  psc_ff;
  mies_pkg::mies_cmd_t  cmd;
  mies_pkg::mies_stat_t stat;
  logic              req, exec, wrAcc, wrReg, zUpd, cUpd, nxtC, push, doSkip, wdTick;
  logic [4:0]        op;
  logic [7:0]        rv, res;
  logic [8:0]        nxtPc, diff, bcd;
  logic [1:0]        nxtBusy;

  // the pc+1 adder is shared by every push and every fall-through
  function automatic logic [8:0] incPc(input logic [8:0] p);
    return p + 9'h001;
  endfunction

  assign cmd  = mies_mcmd(wb_dat_i);
  assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // a command write stalls its ack while a multi-cycle instruction finishes
  assign exec = req && wb_we_i && (wb_adr_i == mies_pkg::ADR_CMD) && (busy_ff == 2'h0);
  assign op   = skip_ff ? mies_pkg::OP_NOP : cmd.op;
  assign rv   = rf[cmd.arg[5:0]];
  // register plus inverted acc plus one, carry out is no-borrow
  assign diff = {1'b0, rv} + {1'b0, ~acc_ff} + 9'h001;
  assign wdTick = pscToWdt_ff ? (&psc_ff) : 1'b1;

  function automatic mies_pkg::mies_cmd_t mies_mcmd(input logic [31:0] d);
    return mies_pkg::mies_cmd_t'(d[17:0]);
  endfunction

  // decimal adjust: low digit then high digit, carry out of the high fix
  always_comb begin
    bcd = {1'b0, acc_ff};
    if (acc_ff[3:0] > mies_pkg::BCD_MAX) begin
      bcd = bcd + {1'b0, mies_pkg::BCD_LO_FIX};
    end
    if ((bcd[7:4] > mies_pkg::BCD_MAX) || c_ff || bcd[8]) begin
      bcd = {1'b1, bcd[7:0] + mies_pkg::BCD_HI_FIX};
    end
  end

  // operation decode: result, destination and flag updates
  always_comb begin
    res = 8'h00; wrAcc = 1'b0; wrReg = 1'b0; zUpd = 1'b0; cUpd = 1'b0;
    nxtC = c_ff; push = 1'b0; doSkip = 1'b0; nxtBusy = 2'h0;
    nxtPc = incPc(pc_ff);
    case (op)
      // skip when tested bit is set
      mies_pkg::OP_SKIP_SET: doSkip = rv[cmd.bitSel];
      mies_pkg::OP_CALL_ACC: begin
        push = 1'b1; nxtPc = {table_high_pointer_ff, acc_ff}; nxtBusy = mies_pkg::XTRA_BRANCH;
      end
      mies_pkg::OP_JUMP_ACC: begin
        nxtPc = {table_high_pointer_ff, acc_ff}; nxtBusy = mies_pkg::XTRA_BRANCH;
      end
      mies_pkg::OP_ZERO_ACC: begin wrAcc = 1'b1; zUpd = 1'b1; end
      mies_pkg::OP_ZERO_REG: begin wrReg = 1'b1; zUpd = 1'b1; end
      mies_pkg::OP_INVERT: begin
        res = ~rv; wrReg = cmd.toReg; wrAcc = !cmd.toReg; zUpd = 1'b1;
      end
      mies_pkg::OP_COMPARE: begin
        res = diff[7:0]; zUpd = 1'b1; cUpd = 1'b1; nxtC = diff[8];
      end
      mies_pkg::OP_MINUS_ONE, mies_pkg::OP_PLUS_ONE: begin
        res = (op == mies_pkg::OP_PLUS_ONE) ? rv + 8'h01 : rv - 8'h01;
        wrReg = cmd.toReg; wrAcc = !cmd.toReg; zUpd = 1'b1;
      end
      // step and skip on zero, flags untouched
      mies_pkg::OP_DEC_SKZ, mies_pkg::OP_INC_SKZ: begin
        res = (op == mies_pkg::OP_INC_SKZ) ? rv + 8'h01 : rv - 8'h01;
        wrReg = cmd.toReg; wrAcc = !cmd.toReg; doSkip = (res == 8'h00);
      end
      mies_pkg::OP_BCD_ADJ: begin
        res = bcd[7:0]; wrAcc = 1'b1; cUpd = 1'b1; nxtC = bcd[8];
      end
      mies_pkg::OP_JUMP_PAGED: begin
        nxtPc = {pc_high_buffer_ff, cmd.arg[7:0]}; nxtBusy = mies_pkg::XTRA_BRANCH;
      end
      mies_pkg::OP_OR_REG: begin
        res = acc_ff | rv; wrReg = cmd.toReg; wrAcc = !cmd.toReg; zUpd = 1'b1;
      end
      mies_pkg::OP_OR_IMM: begin res = acc_ff | cmd.arg[7:0]; wrAcc = 1'b1; zUpd = 1'b1; end
      // fpage read; addresses below six are ignored
      mies_pkg::OP_RD_FPAGE: begin
        res = fpage[cmd.arg[3:0]]; wrAcc = (cmd.arg[3:0] >= mies_pkg::FPAGE_LO);
      end
      mies_pkg::OP_CALL_LONG: begin
        push = 1'b1; nxtPc = cmd.arg; nxtBusy = mies_pkg::XTRA_BRANCH;
      end
      mies_pkg::OP_TRAP: begin
        push = 1'b1; nxtPc = mies_pkg::TRAP_VECTOR; nxtBusy = mies_pkg::XTRA_TRAP;
      end
      default: ;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_ff <= 8'h00;
    end else if (exec && wrAcc) begin
      acc_ff <= res;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (exec && wrReg) begin
      rf[cmd.arg[5:0]] <= res;
    end else if (req && wb_we_i && wb_adr_i == mies_pkg::ADR_RDAT && wb_sel_i[0]) begin
      rf[wb_dat_i[13:8]] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (exec && op == mies_pkg::OP_WR_FPAGE && cmd.arg[3:0] >= mies_pkg::FPAGE_LO) begin
      fpage[cmd.arg[3:0]] <= acc_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      z_ff <= 1'b0;
      c_ff <= 1'b0;
    end else if (exec) begin
      if (zUpd) z_ff <= (res == 8'h00);
      if (cUpd) c_ff <= nxtC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gie_ff <= mies_pkg::RST_GIE;
    end else if (exec && op == mies_pkg::OP_IRQ_ON) begin
      gie_ff <= 1'b1;
    end else if (exec && op == mies_pkg::OP_IRQ_OFF) begin
      gie_ff <= 1'b0;
    end
  end

  // program counter, skip and busy; busy counts the extra cycles of a branch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_ff   <= mies_pkg::PC_RESET;
      skip_ff <= 1'b0;
      busy_ff <= 2'h0;
    end else if (exec) begin
      pc_ff   <= nxtPc;
      skip_ff <= doSkip;
      busy_ff <= nxtBusy;
    end else if (busy_ff != 2'h0) begin
      busy_ff <= busy_ff - 2'h1;
    end
  end

  // return stack wraps silently when overfilled, like the hardware stack
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sp_ff <= '0;
    end else if (exec && push) begin
      stk[sp_ff] <= incPc(pc_ff);
      sp_ff      <= sp_ff + SP_W'(1);
    end
  end

  // watchdog and shared prescaler; a timeout beats a kick
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      psc_ff <= '0;
      wdt_ff <= '0;
      toN_ff <= mies_pkg::RST_FLAG_N;
      pdN_ff <= mies_pkg::RST_FLAG_N;
    end else begin
      psc_ff <= (exec && op == mies_pkg::OP_KICK_WD && pscToWdt_ff) ? '0 : psc_ff + PSC_W'(1);
      if (exec && op == mies_pkg::OP_KICK_WD) begin
        wdt_ff <= '0;
        pdN_ff <= 1'b1;
      end else if (wdTick) begin
        wdt_ff <= wdt_ff + WDT_W'(1);
      end
      if (wdTick && (&wdt_ff)) begin
        toN_ff <= 1'b0;
      end else if (exec && op == mies_pkg::OP_KICK_WD) begin
        toN_ff <= 1'b1;
      end
    end
  end

  // control register: table high bit, pc high buffer bit, prescaler assignment
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {pscToWdt_ff, pc_high_buffer_ff, table_high_pointer_ff} <= 3'h0;
      rdSel_ff <= 6'h00;
    end else if (req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == mies_pkg::ADR_CTRL) {pscToWdt_ff, pc_high_buffer_ff, table_high_pointer_ff} <= wb_dat_i[2:0];
      if (wb_adr_i == mies_pkg::ADR_RDAT) rdSel_ff <= wb_dat_i[13:8];
    end
  end

  assign stat = '{busy: (busy_ff != 2'h0), skip: skip_ff, global_irq_enable: gie_ff, toN: toN_ff,
                  pdN: pdN_ff, c: c_ff, z: z_ff, pc: pc_ff, acc: acc_ff};

  // bus answer: one cycle after the request, later for a command write while busy; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !(wb_we_i && wb_adr_i == mies_pkg::ADR_CMD && busy_ff != 2'h0);
      case (wb_adr_i)
        mies_pkg::ADR_STAT:  wb_dat_o <= {8'h00, stat};
        mies_pkg::ADR_RDAT:  wb_dat_o <= {18'h0, rdSel_ff, rf[rdSel_ff]};
        mies_pkg::ADR_CTRL:  wb_dat_o <= {29'h0, pscToWdt_ff, pc_high_buffer_ff, table_high_pointer_ff};
        mies_pkg::ADR_WDOG:  wb_dat_o <= {16'h0, 8'(psc_ff), 8'(wdt_ff)};
        mies_pkg::ADR_STACK: wb_dat_o <= {15'h0, 8'(sp_ff), stk[sp_ff - SP_W'(1)]};
        default:             wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      globalIrqEnable <= mies_pkg::RST_GIE;
      timeoutFlagN    <= mies_pkg::RST_FLAG_N;
    end else begin
      globalIrqEnable <= gie_ff;
      timeoutFlagN    <= toN_ff;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_skip_bit_nop: assert property (exec && op == mies_pkg::OP_SKIP_SET && rv[cmd.bitSel]
    |=> skip_ff) else $error("bit skip not armed");
  a_call_acc_push: assert property (exec && op == mies_pkg::OP_CALL_ACC
    |=> pc_ff == {$past(table_high_pointer_ff), $past(acc_ff)} && stk[$past(sp_ff)] == $past(pc_ff) + 9'h001
    && busy_ff == 2'h1 ##1 busy_ff == 2'h0) else $error("call via acc wrong");
  a_jump_acc_nopush: assert property (exec && op == mies_pkg::OP_JUMP_ACC
    |=> sp_ff == $past(sp_ff) && pc_ff[7:0] == $past(acc_ff)) else $error("jump acc wrong");
  a_zero_acc_flag: assert property (exec && op == mies_pkg::OP_ZERO_ACC
    |=> acc_ff == 8'h00 && z_ff) else $error("acc not cleared");
  a_compare_keeps: assert property (exec && op == mies_pkg::OP_COMPARE
    |=> acc_ff == $past(acc_ff) && c_ff == ($past(rv) >= $past(acc_ff))) else $error("compare bad");
  a_kick_watchdog: assert property (exec && op == mies_pkg::OP_KICK_WD && !(wdTick && &wdt_ff)
    |=> wdt_ff == '0 && toN_ff && pdN_ff) else $error("kick ineffective");
  a_irq_enable: assert property (exec && op == mies_pkg::OP_IRQ_OFF |=> !gie_ff ##1 !globalIrqEnable)
    else $error("irq off failed");
  a_trap_vector: assert property (exec && op == mies_pkg::OP_TRAP
    |=> pc_ff == mies_pkg::TRAP_VECTOR ##0 busy_ff == 2'h2 ##2 busy_ff == 2'h0)
    else $error("trap wrong");
  a_skip_zero_flags: assert property (exec && op == mies_pkg::OP_INC_SKZ
    |=> z_ff == $past(z_ff) && c_ff == $past(c_ff)) else $error("skip op touched flags");

  c_bit_skip: cover property (exec && op == mies_pkg::OP_SKIP_SET ##[1:4] skip_ff && exec);
  c_trap_taken: cover property (exec && op == mies_pkg::OP_TRAP);
  c_cmd_stall: cover property (req && wb_we_i && wb_adr_i == mies_pkg::ADR_CMD && busy_ff != 2'h0);
  c_wdt_timeout: cover property (!toN_ff);
endmodule

// *** mies_tb.sv ***
// self-checking testbench for the instruction execute core
// assumes the core alone on a classic wishbone bus driven from here
`timescale 1ns/1ps
module tb;
  logic        sys_clk, rst, cyc, stb, we, ack, global_irq_enable, toN;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dIn, dOut, s, r;
  logic [8:0]  pcExp, top;
  int          numErrors, nCompared;

  `define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin numErrors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end

  // short watchdog width so a timeout is reached within the run
  mies_core #(.WDT_W(4)) dut (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dIn), .wb_dat_o(dOut), .wb_ack_o(ack),
    .globalIrqEnable(global_irq_enable), .timeoutFlagN(toN));

  // 200 mhz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // one classic cycle: hold until ack is sampled, then release for a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dIn <= d;
    do @(posedge sys_clk); while (ack !== 1'b1 && n++ < 64);
    if (ack !== 1'b1) numErrors++;
    r = dOut;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic ex(input logic [4:0] op, input logic d, input logic [2:0] b,
                    input logic [8:0] a);
    bus(1'b1, mies_pkg::ADR_CMD, {14'h0, op, d, b, a});
    pcExp = pcExp + 9'h001;
  endtask

  task automatic acc(input logic [7:0] v);
    ex(mies_pkg::OP_ZERO_ACC, 1'b0, 3'h0, 9'h000);
    ex(mies_pkg::OP_OR_IMM, 1'b0, 3'h0, {1'b0, v});
  endtask

  task automatic setR(input logic [5:0] a, input logic [7:0] v);
    bus(1'b1, mies_pkg::ADR_RDAT, {18'h0, a, v});
  endtask

  task automatic rdS;
    bus(1'b0, mies_pkg::ADR_STAT, 32'h0);
    s = r;
  endtask

  task automatic rdR;
    bus(1'b0, mies_pkg::ADR_RDAT, 32'h0);
  endtask

  // branch outcome: new pc, stack pointer and top entry
  task automatic chkBr(input logic [8:0] p, input logic [7:0] sp);
    rdS;
    `CHK(s[16:8], p)
    bus(1'b0, mies_pkg::ADR_STACK, 32'h0);
    `CHK(r[16:0], {sp, top})
    pcExp = p;
  endtask

  task automatic conclude;
    $display("compares %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    numErrors++;
    conclude();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, dIn} = '0;
    sel = 4'hf;
    pcExp = 9'h000;
    top = 9'h000;
    numErrors = 0;
    nCompared = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rdS;
    `CHK(s[23:0], 24'h180000)
    `CHK(global_irq_enable, 1'b0)
    $display("test reset done");
    acc(8'h0a);
    rdS;
    `CHK({s[17], s[7:0]}, 9'h00a)
    ex(mies_pkg::OP_ZERO_ACC, 1'b0, 3'h0, 9'h000);
    rdS;
    `CHK({s[17], s[7:0]}, 9'h100)
    setR(6'd5, 8'h34);
    acc(8'h12);
    ex(mies_pkg::OP_COMPARE, 1'b0, 3'h0, 9'd5);
    rdS;
    `CHK({s[18:17], s[7:0]}, 10'h212)
    rdR;
    `CHK(r[7:0], 8'h34)
    acc(8'h35);
    ex(mies_pkg::OP_COMPARE, 1'b0, 3'h0, 9'd5);
    rdS;
    `CHK(s[18:17], 2'b00)
    acc(8'h34);
    ex(mies_pkg::OP_COMPARE, 1'b0, 3'h0, 9'd5);
    rdS;
    `CHK(s[18:17], 2'b11)
    ex(mies_pkg::OP_INVERT, 1'b1, 3'h0, 9'd5);
    rdR;
    `CHK(r[7:0], 8'hcb)
    ex(mies_pkg::OP_ZERO_ACC, 1'b0, 3'h0, 9'h000);
    ex(mies_pkg::OP_INVERT, 1'b0, 3'h0, 9'd5);
    rdS;
    `CHK({s[18:17], s[7:0]}, 10'h234)
    setR(6'd5, 8'h01);
    ex(mies_pkg::OP_MINUS_ONE, 1'b1, 3'h0, 9'd5);
    rdR;
    `CHK(r[7:0], 8'h00)
    setR(6'd5, 8'hff);
    acc(8'h0a);
    ex(mies_pkg::OP_PLUS_ONE, 1'b0, 3'h0, 9'd5);
    rdS;
    `CHK({s[17], s[7:0]}, 9'h100)
    setR(6'd63, 8'h55);
    acc(8'h0a);
    ex(mies_pkg::OP_ZERO_REG, 1'b0, 3'h0, 9'd63);
    rdR;
    `CHK(r[7:0], 8'h00)
    rdS;
    `CHK(s[17], 1'b1)
    setR(6'd5, 8'h50);
    acc(8'haa);
    ex(mies_pkg::OP_OR_REG, 1'b1, 3'h0, 9'd5);
    rdR;
    `CHK(r[7:0], 8'hfa)
    // a borrowing compare clears carry, else the adjust adds the high fix too
    acc(8'hfb);
    ex(mies_pkg::OP_COMPARE, 1'b0, 3'h0, 9'd5);
    acc(8'h4d);
    ex(mies_pkg::OP_BCD_ADJ, 1'b0, 3'h0, 9'h000);
    rdS;
    `CHK({s[18], s[7:0]}, 9'h053)
    acc(8'ha2);
    ex(mies_pkg::OP_BCD_ADJ, 1'b0, 3'h0, 9'h000);
    rdS;
    `CHK({s[18], s[7:0]}, 9'h102)
    $display("test data ops done");
    setR(6'd7, 8'h5a);
    acc(8'h11);
    ex(mies_pkg::OP_SKIP_SET, 1'b0, 3'h3, 9'd7);
    ex(mies_pkg::OP_OR_IMM, 1'b0, 3'h0, 9'h0ee);
    rdS;
    `CHK(s[7:0], 8'h11)
    ex(mies_pkg::OP_SKIP_SET, 1'b0, 3'h2, 9'd7);
    ex(mies_pkg::OP_OR_IMM, 1'b0, 3'h0, 9'h0e0);
    rdS;
    `CHK(s[7:0], 8'hf1)
    setR(6'd7, 8'hff);
    acc(8'h01);
    ex(mies_pkg::OP_INC_SKZ, 1'b1, 3'h0, 9'd7);
    ex(mies_pkg::OP_ZERO_ACC, 1'b0, 3'h0, 9'h000);
    rdS;
    `CHK({s[17], s[7:0]}, 9'h001)
    rdR;
    `CHK(r[7:0], 8'h00)
    setR(6'd7, 8'h01);
    ex(mies_pkg::OP_DEC_SKZ, 1'b0, 3'h0, 9'd7);
    ex(mies_pkg::OP_OR_IMM, 1'b0, 3'h0, 9'h0ff);
    rdS;
    `CHK({s[17], s[16:8], s[7:0]}, {1'b0, pcExp, 8'h00})
    $display("test skips done");
    bus(1'b1, mies_pkg::ADR_CTRL, 32'h3);
    acc(8'h34);
    ex(mies_pkg::OP_CALL_ACC, 1'b0, 3'h0, 9'h000);
    top = pcExp;
    chkBr(9'h134, 8'd1);
    ex(mies_pkg::OP_JUMP_ACC, 1'b0, 3'h0, 9'h000);
    chkBr(9'h134, 8'd1);
    ex(mies_pkg::OP_JUMP_PAGED, 1'b0, 3'h0, 9'h055);
    chkBr(9'h155, 8'd1);
    ex(mies_pkg::OP_CALL_LONG, 1'b0, 3'h0, 9'h1ff);
    top = pcExp;
    chkBr(9'h1ff, 8'd2);
    ex(mies_pkg::OP_TRAP, 1'b0, 3'h0, 9'h000);
    top = pcExp;
    chkBr(9'h001, 8'd3);
    $display("test branches done");
    ex(mies_pkg::OP_IRQ_ON, 1'b0, 3'h0, 9'h000);
    rdS;
    `CHK({s[21], global_irq_enable}, 2'b11)
    ex(mies_pkg::OP_IRQ_OFF, 1'b0, 3'h0, 9'h000);
    rdS;
    `CHK({s[21], global_irq_enable}, 2'b00)
    for (int f = 6; f < 16; f += 9) begin
      acc(8'ha0 | 8'(f));
      ex(mies_pkg::OP_WR_FPAGE, 1'b0, 3'h0, 9'(f));
    end
    for (int f = 6; f < 16; f += 9) begin
      ex(mies_pkg::OP_ZERO_ACC, 1'b0, 3'h0, 9'h000);
      ex(mies_pkg::OP_RD_FPAGE, 1'b0, 3'h0, 9'(f));
      rdS;
      `CHK(s[7:0], 8'ha0 | 8'(f))
    end
    `CHK(toN, 1'b0)
    bus(1'b1, mies_pkg::ADR_CTRL, 32'h4);
    ex(mies_pkg::OP_KICK_WD, 1'b0, 3'h0, 9'h000);
    bus(1'b0, mies_pkg::ADR_WDOG, 32'h0);
    `CHK(r[7:0], 8'h00)
    `CHK(r[15:8] < 8'h08, 1'b1)
    rdS;
    `CHK({s[20:19], toN}, 3'b111)
    bus(1'b0, 8'h1c, 32'h0);
    `CHK(r, 32'h0)
    $display("test system ops done");
    conclude();
  end
endmodule
